// ==== hdl/ahsc_regs.vh ====
`ifndef AHSC_REGS_VH
`define AHSC_REGS_VH
// Byte offsets
`define AHSC_OFF_CTRL 12'h000
`define AHSC_OFF_SRCSEL 12'h004
`define AHSC_OFF_HOMEREQ 12'h008
`define AHSC_OFF_STATUS 12'h00c
`define AHSC_OFF_RAMPMS 12'h010
`define AHSC_OFF_DELAYS 12'h014
`define AHSC_OFF_SOLTOL 12'h018
`define AHSC_OFF_FAULT 12'h01c
`define AHSC_OFF_HOMEPOS0 12'h020
`define AHSC_OFF_SPEED0 12'h030
`define AHSC_OFF_SPDPER 12'h040
// Control bit positions
`define AHSC_CTRL_LEGACY 0
`define AHSC_CTRL_MEAS_FALL 1
`define AHSC_CTRL_FRAME81 2
`define AHSC_CTRL_AXIS_PARAM 3
`define AHSC_CTRL_SPEED_EN_LSB 4
`define AHSC_CTRL_FAULT_CLR 8
// Legacy source-select bits in the output word
`define AHSC_SRC_BIT_LSB 8
// Frame numbers and external-encoder limit
`define AHSC_FRAME_STANDARD_FRAME_THREE 8'h03
`define AHSC_FRAME_EXT 8'h51
`define AHSC_MAX_EXT_ENC 3'h4
// Reset values
`define AHSC_RST_RAMPMS 16'h0000
`define AHSC_RST_DELAYS 16'h0000
`define AHSC_RST_SOLTOL 4'h0
`define AHSC_RST_SPDPER 32'h000f4240
// Timing
`define AHSC_CLK_HZ 200000000
`define AHSC_MS_NS 1000000
`define AHSC_CLK_NS 5
`define AHSC_MS_CYCLES (`AHSC_MS_NS / `AHSC_CLK_NS)
`define AHSC_S_MS 1000
`endif

// ==== hdl/ahsc_tick_div.v ====
`timescale 1ns/1ps
// Free-running divider giving a one-cycle tick every period cycles.
module ahsc_tick_div #(
   parameter PERIOD = 200000
) (
   input wire pclk,
   input wire presetn,
   output reg tick
);
   reg [31:0] cnt;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 32'h00000000;
         tick <= 1'b0;
      end else if (cnt >= PERIOD - 1) begin
         cnt <= 32'h00000000;
         tick <= 1'b1;
      end else begin
         cnt <= cnt + 32'h00000001;
         tick <= 1'b0;
      end
   end
endmodule

// ==== hdl/ahsc_axis_homing_shutdown.v ====
// How it works
// RULE1 - on homing request, latch encoder value at next zero mark as home position
// RULE2 - measuring and homing jobs never active together on one axis
// RULE3 - legacy mode off: homing always uses the axis's own encoder zero mark
// RULE4 - legacy mode on: source from output word, not from encoder control word
// RULE5 - output word bits 8..11 pick axes 1..4: 0 encoder mark, 1 external rising
// RULE6 - controller sets source bit before requesting reference-mark search
// RULE7 - source bits may change in operation; next requests use the new source
// RULE8 - external zero mark homing always triggers on the rising edge
// RULE9 - controller handles cam, slows axis, then requests homing to encoder mark
// RULE10 - measuring input captures on rising or falling edge, never both
// RULE11 - device computes actual speed per enabled encoder into the speed field
// RULE12 - up to four external encoders without axis, only with frame 81
// RULE13 - frame 3 with encoders but no axis parameterized: ready stays low
// RULE14 - fault ramps all setpoints linearly to zero over 0..65535 ms from maximum
// RULE15 - ramp triggers: over-temperature, sign-of-life failure, sync loss
// RULE16 - ramp duration zero: fault releases drives to coast
// RULE17 - over-temperature starts 0..65535 s delay; ramp only when it expires
// RULE18 - alarm clearing during delay resets the timer, no ramp
// RULE19 - sign-of-life failures counted; ramp once count exceeds the tolerance
// RULE20 - homing request stays armed until capture or withdrawal; one capture each
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
`include "ahsc_regs.vh"
module ahsc_axis_homing_shutdown #(
   parameter AXES = 4,
   parameter MS_CYCLES = `AHSC_MS_CYCLES
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   input wire [15:0] output_word,
   input wire [AXES-1:0] encoder_n_control_word_home,
   input wire [AXES-1:0] encoder_n_control_word_src_ext,
   input wire [AXES-1:0] measure_job,
   input wire [AXES-1:0] encoder_zero_mark,
   input wire [AXES-1:0] ext_zero_mark,
   input wire [AXES-1:0] measure_input,
   input wire [AXES*32-1:0] encoder_value,
   input wire [7:0] frame_type,
   input wire [2:0] encoder_count,
   input wire temp_alarm,
   input wire sign_of_life_fail,
   input wire sync_lost,
   input wire [15:0] setpoint_in,
   output reg [15:0] setpoint_out,
   output reg drive_coast,
   output reg ramp_active,
   output reg ready,
   output reg config_error,
   output reg [AXES-1:0] home_done,
   output reg [AXES*32-1:0] home_position,
   output reg [AXES-1:0] measure_done,
   output reg [AXES*32-1:0] measure_value,
   output reg [AXES*32-1:0] actual_speed_field
);
   reg [31:0] ctrl;
   reg [15:0] ramp_ms;
   reg [15:0] delay_s;
   reg [3:0] sol_tol;
   reg [31:0] speed_period;
   reg [4:0] sol_cnt;
   reg [31:0] delay_cnt;
   reg [15:0] ramp_ms_cnt;
   reg [15:0] ramp_step;
   reg [3:0] fault_flags;
   reg temp_d;
   reg sol_d;
   wire ms_tick;
   wire legacy_source_select_mode = ctrl[`AHSC_CTRL_LEGACY];
   wire wr = psel & penable & pwrite;
   wire [AXES-1:0] src_ext;
   wire [AXES-1:0] capture_ev;
   wire temp_expired;
   wire fault_now;
   wire [31:0] ramp_quot;
   wire clr_ok;

   ahsc_tick_div #(
      .PERIOD(MS_CYCLES)
   ) u_ms (
      .pclk(pclk),
      .presetn(presetn),
      .tick(ms_tick)
   );

   assign pready = 1'b1;
   assign pslverr = 1'b0;

   // Register writes; fault-clear bit self-clears
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= 32'h00000000;
         ramp_ms <= `AHSC_RST_RAMPMS;
         delay_s <= `AHSC_RST_DELAYS;
         sol_tol <= `AHSC_RST_SOLTOL;
         speed_period <= `AHSC_RST_SPDPER;
      end else begin
         ctrl[`AHSC_CTRL_FAULT_CLR] <= 1'b0;
         if (wr) begin
            case (paddr)
               `AHSC_OFF_CTRL: ctrl <= {23'h000000, pwdata[8:0]};
               `AHSC_OFF_RAMPMS: ramp_ms <= pwdata[15:0];
               `AHSC_OFF_DELAYS: delay_s <= pwdata[15:0];
               `AHSC_OFF_SOLTOL: sol_tol <= pwdata[3:0];
               `AHSC_OFF_SPDPER: speed_period <= pwdata;
               default: ;
            endcase
         end
      end
   end

   // Read mux, registered data
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel & ~penable & ~pwrite) begin
         case (paddr)
            `AHSC_OFF_CTRL: prdata <= ctrl;
            `AHSC_OFF_SRCSEL: prdata <= {28'h0000000, src_ext};
            `AHSC_OFF_HOMEREQ: prdata <= {28'h0000000, home_done};
            `AHSC_OFF_STATUS: prdata <= {24'h000000, config_error, ready, drive_coast, ramp_active, sol_cnt[3:0]};
            `AHSC_OFF_RAMPMS: prdata <= {16'h0000, ramp_ms};
            `AHSC_OFF_DELAYS: prdata <= {16'h0000, delay_s};
            `AHSC_OFF_SOLTOL: prdata <= {28'h0000000, sol_tol};
            `AHSC_OFF_FAULT: prdata <= {28'h0000000, fault_flags};
            `AHSC_OFF_SPDPER: prdata <= speed_period;
            default: begin
               if (paddr >= `AHSC_OFF_HOMEPOS0 && paddr < `AHSC_OFF_SPEED0)
                  prdata <= home_position[paddr[3:2]*32 +: 32];
               else if (paddr >= `AHSC_OFF_SPEED0 && paddr < `AHSC_OFF_SPDPER)
                  prdata <= actual_speed_field[paddr[3:2]*32 +: 32];
               else
                  prdata <= 32'h00000000;
            end
         endcase
      end
   end

   // Per-axis homing, measuring and speed
   genvar g;
   generate
      for (g = 0; g < AXES; g = g + 1) begin : g_axis
         reg ext_d;
         reg enc_d;
         reg meas_d;
         reg armed;
         reg [31:0] spd_last;
         reg [31:0] spd_cnt;
         // Source bit is sampled live so a change applies to the next request
         assign src_ext[g] = legacy_source_select_mode ? output_word[`AHSC_SRC_BIT_LSB + g] : // RULE4 RULE5 RULE7
            1'b0; // RULE3
         // External source triggers on the rising edge only
         assign capture_ev[g] = src_ext[g] ? (ext_zero_mark[g] & ~ext_d) : // RULE8
            (encoder_zero_mark[g] & ~enc_d);
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ext_d <= 1'b0;
               enc_d <= 1'b0;
               meas_d <= 1'b0;
               armed <= 1'b0;
               home_done[g] <= 1'b0;
               home_position[g*32 +: 32] <= 32'h00000000;
               measure_done[g] <= 1'b0;
               measure_value[g*32 +: 32] <= 32'h00000000;
               spd_last <= 32'h00000000;
               spd_cnt <= 32'h00000000;
               actual_speed_field[g*32 +: 32] <= 32'h00000000;
            end else begin
               ext_d <= ext_zero_mark[g];
               enc_d <= encoder_zero_mark[g];
               meas_d <= measure_input[g];
               // Homing wins when both jobs are requested at once
               if (!encoder_n_control_word_home[g]) begin
                  armed <= 1'b0; // RULE20
                  home_done[g] <= 1'b0;
               end else if (!home_done[g] && !armed) begin
                  armed <= 1'b1; // RULE20
               end else if (armed && capture_ev[g]) begin
                  armed <= 1'b0; // RULE20
                  home_done[g] <= 1'b1; // RULE1
                  home_position[g*32 +: 32] <= encoder_value[g*32 +: 32]; // RULE1
               end
               if (!measure_job[g] || encoder_n_control_word_home[g]) begin
                  measure_done[g] <= 1'b0; // RULE2
               end else if (!measure_done[g] && (ctrl[`AHSC_CTRL_MEAS_FALL] ?
                     (~measure_input[g] & meas_d) : (measure_input[g] & ~meas_d))) begin // RULE10
                  measure_done[g] <= 1'b1;
                  measure_value[g*32 +: 32] <= encoder_value[g*32 +: 32];
               end
               // Speed: position change per configurable window
               if (ctrl[`AHSC_CTRL_SPEED_EN_LSB + g]) begin
                  if (spd_cnt >= speed_period - 32'h00000001) begin
                     spd_cnt <= 32'h00000000;
                     spd_last <= encoder_value[g*32 +: 32];
                     actual_speed_field[g*32 +: 32] <= encoder_value[g*32 +: 32] - spd_last; // RULE11
                  end else begin
                     spd_cnt <= spd_cnt + 32'h00000001;
                  end
               end else begin
                  spd_cnt <= 32'h00000000;
                  actual_speed_field[g*32 +: 32] <= 32'h00000000;
               end
            end
         end
      end
   endgenerate

   // Temperature delay in ms ticks; clears when the alarm drops
   assign temp_expired = temp_d && (delay_cnt >= {16'h0000, delay_s} * `AHSC_S_MS); // RULE17
   assign fault_now = temp_expired || (sol_cnt > {1'b0, sol_tol}) || sync_lost; // RULE15 RULE19
   // The sign-of-life count clears on the clear edge itself, so from sign of life only a new failure may hold the clear off
   assign clr_ok = !temp_expired && !sync_lost && !(sign_of_life_fail && !sol_d);
   assign ramp_quot = 32'h0000ffff / {16'h0000, ramp_ms};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         temp_d <= 1'b0;
         sol_d <= 1'b0;
         delay_cnt <= 32'h00000000;
         sol_cnt <= 5'h00;
         fault_flags <= 4'h0;
      end else begin
         temp_d <= temp_alarm;
         sol_d <= sign_of_life_fail;
         if (!temp_alarm) begin
            delay_cnt <= 32'h00000000; // RULE18
         end else if (ms_tick && !temp_expired) begin
            delay_cnt <= delay_cnt + 32'h00000001; // RULE17
         end
         // New failures are counted even while clearing
         if (sign_of_life_fail && !sol_d && sol_cnt != 5'h1f) begin
            sol_cnt <= sol_cnt + 5'h01; // RULE19
         end else if (ctrl[`AHSC_CTRL_FAULT_CLR]) begin
            sol_cnt <= 5'h00;
         end
         fault_flags <= (ctrl[`AHSC_CTRL_FAULT_CLR] ? 4'h0 : fault_flags) |
            {1'b0, sync_lost, sol_cnt > {1'b0, sol_tol}, temp_expired};
      end
   end

   // Step is registered so the divider stays out of the ramp path; a zero duration never divides
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ramp_step <= 16'hffff;
      end else if (ramp_ms == 16'h0000) begin
         ramp_step <= 16'hffff;
      end else begin
         ramp_step <= ramp_quot[15:0];
      end
   end

   // Shutdown ramp: slope fixed from full scale, so remaining time scales with setpoint
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ramp_active <= 1'b0;
         drive_coast <= 1'b0;
         ramp_ms_cnt <= 16'h0000;
         setpoint_out <= 16'h0000;
      end else if (!ramp_active && !drive_coast) begin
         setpoint_out <= setpoint_in;
         if (fault_now) begin
            if (ramp_ms == 16'h0000) begin
               drive_coast <= 1'b1; // RULE16
               setpoint_out <= 16'h0000;
            end else begin
               ramp_active <= 1'b1; // RULE14
               ramp_ms_cnt <= 16'h0000;
            end
         end
      end else if (ctrl[`AHSC_CTRL_FAULT_CLR] && clr_ok) begin
         ramp_active <= 1'b0;
         drive_coast <= 1'b0;
      end else if (ramp_active && ms_tick) begin
         // Each ms the setpoint drops by full scale / ramp_ms
         if (ramp_ms_cnt != 16'hffff)
            ramp_ms_cnt <= ramp_ms_cnt + 16'h0001;
         if ({16'h0000, ramp_ms_cnt} + 32'h00000001 >= {16'h0000, ramp_ms} ||
               setpoint_out <= ramp_step)
            setpoint_out <= 16'h0000; // RULE14
         else
            setpoint_out <= setpoint_out - ramp_step; // RULE14
      end
   end

   // Ready output and external-encoder configuration check
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready <= 1'b0;
         config_error <= 1'b0;
      end else begin
         config_error <= !ctrl[`AHSC_CTRL_AXIS_PARAM] && encoder_count != 3'h0 &&
            (frame_type != `AHSC_FRAME_EXT || encoder_count > `AHSC_MAX_EXT_ENC); // RULE12
         ready <= !(frame_type == `AHSC_FRAME_STANDARD_FRAME_THREE && !ctrl[`AHSC_CTRL_AXIS_PARAM] &&
            encoder_count != 3'h0) && !ramp_active && !drive_coast; // RULE13
      end
   end
endmodule

// ==== verif/ahsc_ctl_model.sv ====
`timescale 1ns/1ps
// Motion controller side: source bits, homing requests and zero marks
module ahsc_ctl_model (
   input wire pclk,
   output reg [15:0] output_word,
   output reg [3:0] home_req,
   output reg [3:0] enc_mark,
   output reg [3:0] ext_mark
);
   initial begin
      output_word = 16'h0;
      home_req = 4'h0;
      enc_mark = 4'h0;
      ext_mark = 4'h0;
   end
   task automatic arm(input int ax, input bit ext);
      @(posedge pclk);
      output_word[8+ax] <= ext;
      @(posedge pclk);
      home_req[ax] <= 1'b1;
      repeat (3) @(posedge pclk);
   endtask
   task automatic pulse(input int ax, input bit ext);
      @(posedge pclk);
      if (ext) ext_mark[ax] <= 1'b1;
      else enc_mark[ax] <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_mark[ax] <= 1'b0;
      enc_mark[ax] <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask
   task automatic drop(input int ax);
      @(posedge pclk);
      home_req[ax] <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
endmodule

// ==== verif/ahsc_checker_assertions.sv ====
`timescale 1ns/1ps
module ahsc_checker #(
   parameter AXES = 4
) (
   input wire pclk,
   input wire presetn,
   input wire [AXES-1:0] encoder_n_control_word_home,
   input wire [AXES-1:0] measure_done,
   input wire sync_lost,
   input wire [15:0] setpoint_out,
   input wire drive_coast,
   input wire ramp_active,
   input wire [AXES-1:0] home_done,
   input wire [AXES*32-1:0] home_position
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_done_needs_req: assert property ($rose(home_done[0]) |-> $past(encoder_n_control_word_home[0]))
      else $error("home capture without request");
   a_done_stands: assert property (home_done[0] && encoder_n_control_word_home[0] |=> home_done[0])
      else $error("home capture lost while armed");
   a_done_drop: assert property (!encoder_n_control_word_home[0] |-> ##[1:2] !home_done[0])
      else $error("home capture kept after withdrawal");
   a_pos_hold: assert property (home_done[0] && $past(home_done[0]) |-> $stable(home_position[31:0]))
      else $error("second capture on one request");
   a_meas_excl: assert property (encoder_n_control_word_home[0] |-> ##1 !measure_done[0])
      else $error("measure active during homing");
   a_sync_ramp: assert property (sync_lost |-> ##[1:3] (ramp_active || drive_coast))
      else $error("sync loss without shutdown");
   a_ramp_down: assert property (ramp_active && $past(ramp_active) |-> setpoint_out <= $past(setpoint_out))
      else $error("setpoint rose during ramp");
   a_coast_zero: assert property (drive_coast && $past(drive_coast) |-> setpoint_out == 16'h0)
      else $error("setpoint not zero while coasting");
endmodule
bind ahsc_axis_homing_shutdown ahsc_checker #(.AXES(AXES)) chk (.pclk(pclk), .presetn(presetn),
   .encoder_n_control_word_home(encoder_n_control_word_home), .measure_done(measure_done), .sync_lost(sync_lost),
   .setpoint_out(setpoint_out), .drive_coast(drive_coast), .ramp_active(ramp_active), .home_done(home_done),
   .home_position(home_position));

// ==== verif/ahsc_axis_homing_shutdown_bench.sv ====
`timescale 1ns/1ps
`include "ahsc_regs.vh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_errors++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module ahsc_axis_homing_shutdown_bench;
   reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   reg [11:0] paddr = 0;
   reg [31:0] pwdata = 0, rd;
   reg [3:0] measure_job = 0, measure_input = 0;
   reg [127:0] encv = 0;
   reg [7:0] frame_type = 8'h03;
   reg [2:0] encoder_count = 3'h1;
   reg temp_alarm = 0, sol_fail = 0, sync_lost = 0;
   reg [15:0] setpoint_in = 16'hffff;
   wire pready, pslverr, drive_coast, ramp_active, ready, config_error;
   wire [15:0] output_word, setpoint_out;
   wire [3:0] home_req, enc_mark, ext_mark, home_done, measure_done;
   wire [31:0] prdata;
   wire [127:0] home_position, measure_value, actual_speed_field;
   int n_errors = 0, samples_checked = 0;
   ahsc_ctl_model ctl (.pclk(pclk), .output_word(output_word), .home_req(home_req), .enc_mark(enc_mark),
      .ext_mark(ext_mark));
   // Short ms tick keeps the delay and ramp tests inside the run budget
   ahsc_axis_homing_shutdown #(.AXES(4), .MS_CYCLES(20)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .output_word(output_word), .encoder_n_control_word_home(home_req),
      .encoder_n_control_word_src_ext(4'h0), .measure_job(measure_job), .encoder_zero_mark(enc_mark),
      .ext_zero_mark(ext_mark), .measure_input(measure_input), .encoder_value(encv), .frame_type(frame_type),
      .encoder_count(encoder_count), .temp_alarm(temp_alarm), .sign_of_life_fail(sol_fail), .sync_lost(sync_lost),
      .setpoint_in(setpoint_in), .setpoint_out(setpoint_out), .drive_coast(drive_coast), .ramp_active(ramp_active),
      .ready(ready), .config_error(config_error), .home_done(home_done), .home_position(home_position),
      .measure_done(measure_done), .measure_value(measure_value), .actual_speed_field(actual_speed_field));
   initial begin
      forever #2.5 pclk = ~pclk;
   end
   task end_of_test;
      if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic apb(input bit w, input [11:0] a, input [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic home_try(input int a, input bit src, input bit m, input bit e);
      encv[a*32+:32] <= 32'h5a5a0000 + a;
      ctl.arm(a, src);
      ctl.pulse(a, m);
      `CHK(home_done[a], e)
      if (e) `CHK(home_position[a*32+:32], 32'h5a5a0000 + a)
      encv[a*32+:32] <= 32'h0;
      ctl.pulse(a, m);
      if (e) `CHK(home_position[a*32+:32], 32'h5a5a0000 + a)
      ctl.drop(a);
      `CHK(home_done[a], 1'b0)
   endtask
   task automatic clr;
      temp_alarm <= 0;
      sol_fail <= 0;
      sync_lost <= 0;
      apb(1, `AHSC_OFF_CTRL, 32'h109);
      repeat (3) @(posedge pclk);
      `CHK({ramp_active, drive_coast}, 2'b00)
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1;
      apb(0, `AHSC_OFF_SPDPER, 0);
      `CHK(rd, 32'h000f4240)
      apb(0, 12'h0fc, 0);
      `CHK(rd, 32'h0)
      `CHK(ready, 1'b0)
      `CHK(config_error, 1'b1)
      frame_type <= 8'h51;
      repeat (2) @(posedge pclk);
      `CHK({config_error, ready}, 2'b01)
      encoder_count <= 3'h5;
      repeat (2) @(posedge pclk);
      `CHK(config_error, 1'b1)
      frame_type <= 8'h03;
      encoder_count <= 3'h1;
      apb(1, `AHSC_OFF_CTRL, 32'h8);
      repeat (3) @(posedge pclk);
      `CHK(ready, 1'b1)
      `CHK(config_error, 1'b0)
      for (int a = 0; a < 4; a++) begin
         home_try(a, 1, 0, 1);
         home_try(a, 1, 1, 0);
      end
      apb(1, `AHSC_OFF_CTRL, 32'h9);
      for (int a = 0; a < 4; a++) begin
         home_try(a, 1, 1, 1);
         home_try(a, 1, 0, 0);
         home_try(a, 0, 0, 1);
      end
      apb(0, `AHSC_OFF_HOMEPOS0 + 12'h4, 0);
      `CHK(rd, 32'h5a5a0001)
      measure_job <= 4'h1;
      encv[31:0] <= 32'h00000777;
      @(posedge pclk);
      measure_input <= 4'h1;
      repeat (3) @(posedge pclk);
      `CHK({measure_done[0], measure_value[31:0]}, 33'h100000777)
      ctl.arm(0, 0);
      `CHK(measure_done[0], 1'b0)
      ctl.drop(0);
      apb(1, `AHSC_OFF_CTRL, 32'hb);
      repeat (2) @(posedge pclk);
      `CHK(measure_done[0], 1'b0)
      encv[31:0] <= 32'h00000888;
      measure_input <= 4'h0;
      repeat (3) @(posedge pclk);
      `CHK({measure_done[0], measure_value[31:0]}, 33'h100000888)
      measure_job <= 4'h0;
      encv[31:0] <= 32'h00000100;
      apb(1, `AHSC_OFF_SPDPER, 10);
      apb(1, `AHSC_OFF_CTRL, 32'h19);
      repeat (12) @(posedge pclk);
      `CHK(actual_speed_field[31:0], 32'h100)
      encv[31:0] <= 32'h00000150;
      repeat (10) @(posedge pclk);
      apb(0, `AHSC_OFF_SPEED0, 0);
      `CHK(rd, 32'h50)
      apb(1, `AHSC_OFF_RAMPMS, 2);
      sync_lost <= 1;
      repeat (3) @(posedge pclk);
      `CHK({ramp_active, drive_coast}, 2'b10)
      repeat (80) @(posedge pclk);
      `CHK(setpoint_out, 16'h0)
      apb(0, `AHSC_OFF_FAULT, 0);
      `CHK(rd, 32'h4)
      clr();
      apb(1, `AHSC_OFF_RAMPMS, 0);
      sync_lost <= 1;
      repeat (3) @(posedge pclk);
      `CHK({drive_coast, setpoint_out}, 17'h10000)
      clr();
      apb(1, `AHSC_OFF_RAMPMS, 2);
      apb(1, `AHSC_OFF_SOLTOL, 1);
      for (int i = 0; i < 2; i++) begin
         sol_fail <= 1;
         repeat (2) @(posedge pclk);
         sol_fail <= 0;
         repeat (8) @(posedge pclk);
         `CHK(ramp_active, i == 1)
      end
      clr();
      // One second of delay is 1000 ticks of 20 cycles
      apb(1, `AHSC_OFF_DELAYS, 1);
      temp_alarm <= 1;
      repeat (100) @(posedge pclk);
      temp_alarm <= 0;
      repeat (20100) @(posedge pclk);
      `CHK(ramp_active, 1'b0)
      temp_alarm <= 1;
      repeat (19900) @(posedge pclk);
      `CHK(ramp_active, 1'b0)
      repeat (300) @(posedge pclk);
      `CHK(ramp_active, 1'b1)
      end_of_test();
   end
   initial begin
      repeat (60000) @(posedge pclk);
      n_errors++;
      end_of_test();
   end
endmodule
